// ---- design/pfc_port1_flow_ctrl.sv ----
// Port 1 flow control configuration and status register, Wishbone slave.
// Assumes a classic single-cycle Wishbone master, synchronous inputs on
// ref_clk, and strap pins that are stable around the release of rst_b.
//
// Function
// - Bit 6 turns half-duplex backpressure on/off.
// - Read-only bit 5 shows duplex, 1 half.
// - Read-only bit 4 shows receive pause active.
// - Read-only bit 3 shows transmit pause active.
// - Bit 2 enables pause detection when manual.
// - Bit 1 enables pause generation when manual.
// - Auto mode with negotiation uses negotiated pause.
// - Negotiation off applies the enable bits.
// - Manual select: enable bits alone decide, full duplex.
// - Forced modes hold manual select at one.
// - Manual select read-only in forced modes.
// - Forced default one; loader never overwrites it.
// - Field defaults from straps, loader may replace.
// - Loader rewrite updates the affected fields.
// - Status defaults derive from several straps.
// - Writes leave transceiver advertisement untouched.
`timescale 1ns/10ps
`default_nettype none

`include "pfc_cfg.svh"

module pfc_port1_flow_ctrl (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    // Wishbone slave
    input  wire pfc_pkg::pfc_wb_req_t wb_req,
    output logic                      wb_ack,
    output logic [31:0]               wb_dat_o,
    // Straps and configuration loader
    input  wire pfc_pkg::pfc_strap_t  strap_pins,
    input  wire logic                 loader_load,
    input  wire pfc_pkg::pfc_strap_t  loader_straps,
    // Port 1 link state
    input  wire pfc_pkg::pfc_mode_t   port_mode,
    input  wire logic                 an_enable,
    input  wire logic                 an_rx_pause,
    input  wire logic                 an_tx_pause,
    input  wire logic                 link_half_duplex,
    // Controls to the port 1 MAC
    output logic                      port1_backpressure_enable,
    output logic                      port1_manual_pause_select,
    output logic                      port1_rx_pause_active,
    output logic                      port1_tx_pause_active,
    output logic                      port1_duplex_status
);

    // ****************************************
    // State
    // ****************************************
    pfc_pkg::pfc_state_t st_reg;
    pfc_pkg::pfc_state_t st_next;

    logic        forced_mode;
    logic        req_live;
    logic        hit;
    logic        wr_lane0;
    logic        manual_eff;
    logic [31:0] reg_image;

    // Forced modes have no auto-negotiation at all
    assign forced_mode = (port_mode == pfc_pkg::PFC_MODE_MII_PHY)
                      || (port_mode == pfc_pkg::PFC_MODE_RMII_PHY)
                      || (port_mode == pfc_pkg::PFC_MODE_MII_MAC);

    // One request is answered once; ack drops the cycle after it rose
    assign req_live = wb_req.cyc && wb_req.stb && !st_reg.ack;
    assign hit      = (wb_req.adr == `PFC_FC1_OFFSET);
    assign wr_lane0 = req_live && hit && wb_req.we && wb_req.sel[0];

    // Upper bits are constant zero and never stored
    always_comb begin
        reg_image                  = `PFC_RST_DATA;
        reg_image[`PFC_BIT_BP]     = st_reg.bp_en;
        reg_image[`PFC_BIT_DUP]    = st_reg.dup;
        reg_image[`PFC_BIT_RX_ACT] = st_reg.rx_act;
        reg_image[`PFC_BIT_TX_ACT] = st_reg.tx_act;
        reg_image[`PFC_BIT_RX_EN]  = st_reg.rx_en;
        reg_image[`PFC_BIT_TX_EN]  = st_reg.tx_en;
        reg_image[`PFC_BIT_MANUAL] = st_reg.manual;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next = st_reg;

        // Bus answer: unmapped reads return zero, unmapped writes vanish
        st_next.ack = req_live;
        if (req_live && hit && !wb_req.we) begin
            st_next.rdata = reg_image;
        end else if (req_live) begin
            st_next.rdata = `PFC_RST_DATA;
        end

        // Straps are caught on the first edge after reset release
        if (!st_reg.strap_done) begin
            st_next.strap_done = 1'h1;
            st_next.bp_en      = strap_pins.port1_backpressure_strap;
            st_next.rx_en      = strap_pins.port1_pause_strap;
            st_next.tx_en      = strap_pins.port1_pause_strap;
            st_next.manual     = strap_pins.port1_manual_select_strap;
        end else if (wr_lane0) begin
            // Only the local bits change; advertisement lives in the PHY
            st_next.bp_en = wb_req.dat[`PFC_BIT_BP];
            st_next.rx_en = wb_req.dat[`PFC_BIT_RX_EN];
            st_next.tx_en = wb_req.dat[`PFC_BIT_TX_EN];
            if (!forced_mode) begin
                st_next.manual = wb_req.dat[`PFC_BIT_MANUAL];
            end
        end

        // A loader rewrite beats a bus write in the same cycle
        if (st_reg.strap_done && loader_load) begin
            st_next.bp_en  = loader_straps.port1_backpressure_strap;
            st_next.rx_en  = loader_straps.port1_pause_strap;
            st_next.tx_en  = loader_straps.port1_pause_strap;
            if (!forced_mode) begin
                st_next.manual = loader_straps.port1_manual_select_strap;
            end
        end

        // Forced modes pin the select high whatever was written
        if (forced_mode) begin
            st_next.manual = `PFC_FORCED_MANUAL;
        end

        // Status follows from the new fields, so the first values after
        // reset derive from the strap set together with the link inputs
        manual_eff     = st_next.manual || !an_enable;
        st_next.dup    = link_half_duplex;
        if (link_half_duplex) begin
            // Pause frames exist only in full duplex
            st_next.rx_act = 1'h0;
            st_next.tx_act = 1'h0;
        end else if (manual_eff) begin
            st_next.rx_act = st_next.rx_en;
            st_next.tx_act = st_next.tx_en;
        end else begin
            st_next.rx_act = an_rx_pause;
            st_next.tx_act = an_tx_pause;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign wb_ack                    = st_reg.ack;
    assign wb_dat_o                  = st_reg.rdata;
    assign port1_backpressure_enable = st_reg.bp_en;
    assign port1_manual_pause_select = st_reg.manual;
    assign port1_rx_pause_active     = st_reg.rx_act;
    assign port1_tx_pause_active     = st_reg.tx_act;
    assign port1_duplex_status       = st_reg.dup;

    // ****************************************
    // Checks
    // ****************************************
    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // Nothing sampled during the strap catch cycle
    logic chk_ok;
    assign chk_ok = st_reg.strap_done;

    bp_write_a: assert property (
        chk_ok && wr_lane0 && !loader_load |=> st_reg.bp_en == $past(wb_req.dat[`PFC_BIT_BP])
    ) else $error("backpressure bit did not take written value");

    dup_follow_a: assert property (
        chk_ok |=> port1_duplex_status == $past(link_half_duplex)
    ) else $error("duplex status does not follow link");

    rx_manual_a: assert property (
        chk_ok && (st_next.manual || !an_enable) && !link_half_duplex
        |=> port1_rx_pause_active == st_reg.rx_en
    ) else $error("receive pause not from enable bit");

    tx_manual_a: assert property (
        chk_ok && (st_next.manual || !an_enable) && !link_half_duplex
        |=> port1_tx_pause_active == st_reg.tx_en
    ) else $error("transmit pause not from enable bit");

    auto_pause_a: assert property (
        chk_ok && !st_next.manual && an_enable && !link_half_duplex
        |=> port1_rx_pause_active == $past(an_rx_pause)
            && port1_tx_pause_active == $past(an_tx_pause)
    ) else $error("negotiated pause not applied");

    half_nopause_a: assert property (
        link_half_duplex |=> !port1_rx_pause_active && !port1_tx_pause_active
    ) else $error("pause active in half duplex");

    forced_manual_a: assert property (
        rst_b && forced_mode |=> port1_manual_pause_select
    ) else $error("manual select not held high in forced mode");

    loader_update_a: assert property (
        chk_ok && loader_load |=> st_reg.bp_en == $past(loader_straps.port1_backpressure_strap)
            && st_reg.rx_en == $past(loader_straps.port1_pause_strap)
    ) else $error("loader values not applied");

    strap_catch_a: assert property (
        rst_b && !st_reg.strap_done
        |=> st_reg.bp_en == $past(strap_pins.port1_backpressure_strap)
            && st_reg.strap_done
    ) else $error("straps not caught after reset");

    reserved_zero_a: assert property (
        wb_ack |-> wb_dat_o[31:7] == 25'h0
    ) else $error("reserved bits read nonzero");

    ack_single_a: assert property (
        wb_ack |=> !wb_ack
    ) else $error("ack held longer than one cycle");

    ack_timely_a: assert property (
        wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack
    ) else $error("request not answered next cycle");

    // ****************************************
    // Checks on bus writes and reads
    // ****************************************
    // A loader pulse in the same cycle wins, so those cycles are left out
    rx_write_a: assert property (
        chk_ok && wr_lane0 && !loader_load
        |=> st_reg.rx_en == $past(wb_req.dat[`PFC_BIT_RX_EN])
    ) else $error("receive enable did not take written value");

    tx_write_a: assert property (
        chk_ok && wr_lane0 && !loader_load
        |=> st_reg.tx_en == $past(wb_req.dat[`PFC_BIT_TX_EN])
    ) else $error("transmit enable did not take written value");

    manual_write_a: assert property (
        chk_ok && wr_lane0 && !loader_load && !forced_mode
        |=> st_reg.manual == $past(wb_req.dat[`PFC_BIT_MANUAL])
    ) else $error("manual select did not take written value");

    // Refused writes (other address, lane 0 off) must leave every writable field alone
    fields_hold_a: assert property (
        chk_ok && !wr_lane0 && !loader_load
        |=> st_reg.bp_en == $past(st_reg.bp_en)
            && st_reg.rx_en == $past(st_reg.rx_en)
            && st_reg.tx_en == $past(st_reg.tx_en)
    ) else $error("field changed without write or load");

    manual_hold_a: assert property (
        chk_ok && !forced_mode && !wr_lane0 && !loader_load
        |=> st_reg.manual == $past(st_reg.manual)
    ) else $error("manual select changed without write or load");

    refused_zero_a: assert property (
        req_live && (!hit || wb_req.we)
        |=> wb_dat_o == 32'h0
    ) else $error("write or unmapped access returned data");

    rd_image_a: assert property (
        req_live && hit && !wb_req.we
        |=> wb_dat_o == $past(reg_image)
    ) else $error("read data is not the register image");

    ack_quiet_a: assert property (
        !(wb_req.cyc && wb_req.stb) |=> !wb_ack
    ) else $error("ack without a request");

    rdata_keep_a: assert property (
        !req_live |=> wb_dat_o == $past(wb_dat_o)
    ) else $error("read data changed between answers");

    // ****************************************
    // Checks on straps and the loader
    // ****************************************
    loader_tx_a: assert property (
        chk_ok && loader_load
        |=> st_reg.tx_en == $past(loader_straps.port1_pause_strap)
    ) else $error("loader pause value not applied to transmit");

    loader_manual_a: assert property (
        chk_ok && loader_load && !forced_mode
        |=> st_reg.manual == $past(loader_straps.port1_manual_select_strap)
    ) else $error("loader manual value not applied");

    // The release edge itself still resets the flops, hence rst_b in front
    strap_pause_a: assert property (
        rst_b && !st_reg.strap_done
        |=> st_reg.rx_en == $past(strap_pins.port1_pause_strap)
            && st_reg.tx_en == $past(strap_pins.port1_pause_strap)
    ) else $error("pause straps not caught after reset");

    strap_manual_a: assert property (
        rst_b && !st_reg.strap_done && !forced_mode
        |=> st_reg.manual == $past(strap_pins.port1_manual_select_strap)
    ) else $error("manual strap not caught after reset");

    strap_status_a: assert property (
        rst_b && !st_reg.strap_done && !link_half_duplex
            && (forced_mode || strap_pins.port1_manual_select_strap || !an_enable)
        |=> port1_rx_pause_active == $past(strap_pins.port1_pause_strap)
            && port1_tx_pause_active == $past(strap_pins.port1_pause_strap)
    ) else $error("status after reset does not follow the straps");

    strap_auto_a: assert property (
        rst_b && !st_reg.strap_done && !link_half_duplex && !forced_mode
            && !strap_pins.port1_manual_select_strap && an_enable
        |=> port1_rx_pause_active == $past(an_rx_pause)
            && port1_tx_pause_active == $past(an_tx_pause)
    ) else $error("negotiated pause not applied after reset");

    strap_once_a: assert property (
        st_reg.strap_done |=> st_reg.strap_done
    ) else $error("straps caught a second time");

    // ****************************************
    // Checks on status after updates
    // ****************************************
    write_status_a: assert property (
        chk_ok && wr_lane0 && !loader_load && !link_half_duplex
            && (forced_mode || !an_enable)
        |=> port1_tx_pause_active == $past(wb_req.dat[`PFC_BIT_TX_EN])
            && port1_rx_pause_active == $past(wb_req.dat[`PFC_BIT_RX_EN])
    ) else $error("written enables not applied to status");

    loader_status_a: assert property (
        chk_ok && loader_load && !link_half_duplex
            && (forced_mode || !an_enable)
        |=> port1_rx_pause_active == $past(loader_straps.port1_pause_strap)
            && port1_tx_pause_active == $past(loader_straps.port1_pause_strap)
    ) else $error("loaded enables not applied to status");

endmodule // pfc_port1_flow_ctrl

`default_nettype wire

// ---- design/pfc_cfg.svh ----
// Constants for the port 1 flow control register block.
// Included by the package and the design; definitions only.
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define PFC_ADDR_W         12
`define PFC_FC1_OFFSET     12'h1a0

// ****************************************
// Field positions
// ****************************************
`define PFC_BIT_BP         6
`define PFC_BIT_DUP        5
`define PFC_BIT_RX_ACT     4
`define PFC_BIT_TX_ACT     3
`define PFC_BIT_RX_EN      2
`define PFC_BIT_TX_EN      1
`define PFC_BIT_MANUAL     0

// ****************************************
// Reset values, before the straps are caught
// ****************************************
`define PFC_RST_FIELD      1'h0
`define PFC_RST_DATA       32'h0
`define PFC_FORCED_MANUAL  1'h1

`endif

// ---- design/pfc_pkg.sv ----
// Types for the port 1 flow control register block.
// Assumes pfc_cfg.svh is on the include path.
`include "pfc_cfg.svh"

package pfc_pkg;

    // Port 1 operating mode; the last three have no auto-negotiation
    typedef enum logic [1:0] {
        PFC_MODE_INTERNAL_PHY,
        PFC_MODE_MII_PHY,
        PFC_MODE_RMII_PHY,
        PFC_MODE_MII_MAC
    } pfc_mode_t;

    // Strap set, at reset or as rewritten by the configuration loader
    typedef struct packed {
        logic port1_backpressure_strap;
        logic port1_pause_strap;
        logic port1_manual_select_strap;
    } pfc_strap_t;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic                     cyc;
        logic                     stb;
        logic                     we;
        logic [`PFC_ADDR_W-1:0]   adr;
        logic [3:0]               sel;
        logic [31:0]              dat;
    } pfc_wb_req_t;

    // Whole state of the block
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic        strap_done;
        logic        bp_en;
        logic        rx_en;
        logic        tx_en;
        logic        manual;
        logic        dup;
        logic        rx_act;
        logic        tx_act;
    } pfc_state_t;

endpackage

// ---- verification/tb_top.sv ----
// Self-checking bench for the port 1 flow control register block.
// Assumes pfc_cfg.svh on the include path and pfc_pkg compiled first.
`timescale 1ns/10ps
`default_nettype none

`include "pfc_cfg.svh"

module tb_top;
    logic                  ref_clk, rst_b, wb_ack, loader_load;
    logic                  an_enable, an_rx_pause, an_tx_pause, link_half_duplex;
    logic                  o_bp, o_man, o_rxa, o_txa, o_dup;
    logic [31:0]           wb_dat_o, seed, rd, r, d;
    logic                  m_bp, m_rx, m_tx, m_man;
    pfc_pkg::pfc_wb_req_t  wb_req;
    pfc_pkg::pfc_strap_t   strap_pins, loader_straps;
    pfc_pkg::pfc_mode_t    port_mode;
    int                    bad_count, tests_run;

    pfc_port1_flow_ctrl dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .wb_req(wb_req),
        .wb_ack(wb_ack), .wb_dat_o(wb_dat_o), .strap_pins(strap_pins),
        .loader_load(loader_load), .loader_straps(loader_straps), .port_mode(port_mode),
        .an_enable(an_enable), .an_rx_pause(an_rx_pause), .an_tx_pause(an_tx_pause),
        .link_half_duplex(link_half_duplex), .port1_backpressure_enable(o_bp),
        .port1_manual_pause_select(o_man), .port1_rx_pause_active(o_rxa),
        .port1_tx_pause_active(o_txa), .port1_duplex_status(o_dup));

    always #4 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected register image from the bench's own field copy and link inputs
    function automatic logic [31:0] exp_reg();
        logic m, ra, ta;
        m  = (port_mode != pfc_pkg::PFC_MODE_INTERNAL_PHY) ? 1'b1 : m_man;
        ra = link_half_duplex ? 1'b0 : ((m | !an_enable) ? m_rx : an_rx_pause);
        ta = link_half_duplex ? 1'b0 : ((m | !an_enable) ? m_tx : an_tx_pause);
        return {25'h0, m_bp, link_half_duplex, ra, ta, m_rx, m_tx, m};
    endfunction

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Classic cycle: hold until ack is sampled, then release for one cycle
    task automatic wb(input logic we, input logic [11:0] a, input logic [3:0] s,
                      input logic [31:0] dd, output logic [31:0] q);
        int n;
        n = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: dd};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50)
            chk("ack_timeout", 32'h1, 32'h0);
        q = wb_dat_o;
        wb_req <= '0;
        @(posedge ref_clk);
    endtask

    task automatic check_all();
        logic [31:0] e;
        e = exp_reg();
        wb(1'b0, `PFC_FC1_OFFSET, 4'hf, 32'h0, rd);
        chk("register", e, rd);
        chk("ports", {27'h0, e[6], e[0], e[4], e[3], e[5]},
            {27'h0, o_bp, o_man, o_rxa, o_txa, o_dup});
    endtask

    task automatic do_reset(input int md);
        r = xs();
        rst_b <= 1'b0;
        port_mode <= pfc_pkg::pfc_mode_t'(md[1:0]);
        strap_pins <= pfc_pkg::pfc_strap_t'(r[2:0]);
        {an_enable, an_rx_pause, an_tx_pause, link_half_duplex} <= r[7:4];
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        {m_bp, m_rx, m_man} = r[2:0];
        m_tx = r[1];
        repeat (2) @(posedge ref_clk);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        seed = 32'h61c19eb0;
        wb_req = '0;
        strap_pins = '0;
        loader_straps = '0;
        loader_load = 1'b0;
        port_mode = pfc_pkg::PFC_MODE_INTERNAL_PHY;
        {an_enable, an_rx_pause, an_tx_pause, link_half_duplex} = 4'h0;
        bad_count = 0;
        tests_run = 0;
        for (int md = 0; md < 4; md++) begin
            do_reset(md);
            check_all();
            for (int i = 0; i < 40; i++) begin
                r = xs();
                {an_enable, an_rx_pause, an_tx_pause, link_half_duplex} <= r[3:0];
                d = (i == 0) ? 32'hffff_ffff : xs();
                if (r[5:4] == 2'h0) begin
                    // Straps rewritten by the loader; forced modes keep manual select
                    loader_straps <= pfc_pkg::pfc_strap_t'(d[2:0]);
                    loader_load <= 1'b1;
                    @(posedge ref_clk);
                    loader_load <= 1'b0;
                    {m_bp, m_rx} = d[2:1];
                    m_tx = d[1];
                    if (md == 0)
                        m_man = d[0];
                    @(posedge ref_clk);
                end else if (r[5:4] == 2'h1) begin
                    wb(1'b1, 12'h1a4, 4'hf, d, rd);
                    wb(1'b0, 12'h1a4, 4'hf, 32'h0, rd);
                    chk("unmapped", 32'h0, rd);
                end else begin
                    wb(1'b1, `PFC_FC1_OFFSET, (i == 1) ? 4'he : r[11:8], d, rd);
                    if (i != 1 && r[8]) begin
                        {m_bp, m_rx, m_tx} = {d[6], d[2], d[1]};
                        if (md == 0)
                            m_man = d[0];
                    end
                end
                check_all();
            end
        end
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
